/* common/eeprom_loader_pkg.sv */
// package of constants for the serial eeprom configuration loader
package eeprom_loader_pkg;
    // ========================================================
    // eeprom organisation
    localparam int ADDR_BITS = 9;
    localparam logic [8:0] LAST_ADDR_SMALL = 9'h0FF;
    localparam logic [8:0] LAST_ADDR_LARGE = 9'h1FF;
    localparam logic [7:0] PROGRAMMED_MARK = 8'hA5;
    localparam logic [8:0] ADDR_MARK = 9'h000;
    localparam logic [8:0] ADDR_MAC_FIRST = 9'h001;
    localparam logic [8:0] ADDR_MAC_LAST = 9'h006;
    localparam logic [8:0] ADDR_CFG_LAST = 9'h021;
    // ========================================================
    // three-wire opcodes: start bit plus two opcode bits
    localparam logic [2:0] OP_READ = 3'h6;
    localparam logic [2:0] OP_WRITE = 3'h5;
    localparam logic [2:0] OP_ERASE = 3'h7;
    localparam logic [2:0] OP_EWEN = 3'h4;
    localparam logic [8:0] EWEN_ADDR = 9'h180;
    // ========================================================
    // host command codes
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_ERASE = 2'h2;
    localparam logic [1:0] CMD_ENABLE = 2'h3;
    // ========================================================
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int SCLK_HALF_NS = 1000;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * (CLK_HZ / 1_000_000)
        + 999) / 1000;
    localparam int BUSY_TIMEOUT_MS = 10;
    localparam int BUSY_TIMEOUT_CYC = BUSY_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam logic [31:0] READY_SETTLE_CYC = 32'h3;
    localparam logic [47:0] MAC_RESET = 48'h0;
endpackage

/* tb/eeprom_loader_monitor.sv */
// concurrent checks on the configuration loader top ports
`timescale 1ns/1ps
module eeprom_loader_monitor (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, low
    input wire logic large_part, // part size
    input wire logic host_req, // host request
    input wire logic [8:0] host_addr, // host location
    input wire logic host_busy_ff, // host busy
    input wire logic host_done_ff, // host done
    input wire logic host_error_ff, // host error
    input wire logic load_done_ff, // load finished
    input wire logic usb_hold_ff, // usb hold
    input wire logic cfg_valid_ff, // programmed
    input wire logic [47:0] mac_addr_ff, // station address
    input wire logic mac_load_ff, // mac write pulse
    input wire logic cfg_we_ff, // config write
    input wire logic [8:0] cfg_addr_ff, // config location
    input wire logic eeprom_chip_select, // chip select
    input wire logic eeprom_serial_clock // serial clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ========================================================
    // load and hold-off
    a_hold_until_load: assert property (usb_hold_ff != load_done_ff)
        else $error("usb hold not the inverse of load done");
    a_load_sticky: assert property (load_done_ff |=> load_done_ff)
        else $error("load done dropped");
    a_busy_in_load: assert property (!load_done_ff |-> host_busy_ff)
        else $error("host taken during load");
    a_first_read: assert property ($rose(resetn) |-> ##[1:4] eeprom_chip_select)
        else $error("no eeprom frame after reset");
    a_cfg_range: assert property (cfg_we_ff |-> cfg_valid_ff &&
        cfg_addr_ff >= 9'h001 && cfg_addr_ff <= 9'h021)
        else $error("config byte outside load or range");
    a_mac_load: assert property (mac_load_ff |-> cfg_valid_ff && !load_done_ff)
        else $error("mac load without programmed part");
    a_mac_frozen: assert property (load_done_ff && $past(load_done_ff)
        |-> $stable(mac_addr_ff))
        else $error("mac address moved after load");
    // ========================================================
    // host path and link
    a_done_single: assert property (host_done_ff
        |=> !host_done_ff && !host_busy_ff)
        else $error("done not a single pulse");
    a_req_taken: assert property (host_req && !host_busy_ff
        |=> host_busy_ff || host_done_ff)
        else $error("host request not taken");
    a_range_error: assert property (host_req && !host_busy_ff && !large_part
        && host_addr[8] |-> ##[1:2] (host_done_ff && host_error_ff))
        else $error("out of range address not refused");
    a_cs_frame_low: assert property ($fell(eeprom_chip_select)
        |-> !eeprom_serial_clock)
        else $error("chip select fell with clock high");
    c_mac: cover property (mac_load_ff);
    c_err: cover property (host_done_ff && host_error_ff);
    c_blank: cover property ($rose(load_done_ff) && !cfg_valid_ff);
endmodule
bind eeprom_config_loader eeprom_loader_monitor i_mon (.clk(clk),
    .resetn(resetn), .large_part(large_part), .host_req(host_req),
    .host_addr(host_addr), .host_busy_ff(host_busy_ff),
    .host_done_ff(host_done_ff), .host_error_ff(host_error_ff),
    .load_done_ff(load_done_ff), .usb_hold_ff(usb_hold_ff),
    .cfg_valid_ff(cfg_valid_ff), .mac_addr_ff(mac_addr_ff),
    .mac_load_ff(mac_load_ff), .cfg_we_ff(cfg_we_ff),
    .cfg_addr_ff(cfg_addr_ff), .eeprom_chip_select(eeprom_chip_select),
    .eeprom_serial_clock(eeprom_serial_clock));

/* tb/eeprom_model.sv */
// behavioural three-wire byte-wide serial eeprom
`timescale 1ns/1ps
module eeprom_model
    import eeprom_loader_pkg::*;
(
    input wire logic clk, // core clock, for busy timing
    input wire logic large_part, // 512 bytes when high
    input wire logic [31:0] prog_cyc, // programming time
    input wire logic cs, // chip select
    input wire logic sclk, // serial clock
    input wire logic din, // data into part
    output logic dout // data out of part
);
    logic [7:0] mem [0:511]; // byte organised
    logic [19:0] sh = 20'h0;
    logic [7:0] rd = 8'h0;
    logic [31:0] busy_cnt = 32'h0;
    logic drv = 1'b0, obit = 1'b0, stat = 1'b0, ewen = 1'b0, junk = 1'b0;
    int cnt = 0, off;
    initial for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    function automatic int loc(input logic [8:0] a);
        return large_part ? int'(a) : int'(a[7:0]);
    endfunction
    // ========================================================
    // bits taken on sclk rise, read data shifted out after a dummy 0
    always @(posedge sclk) if (cs) begin
        stat = 1'b0;
        sh = {sh[18:0], din};
        cnt++;
        if (cnt == 12 && sh[11:9] == OP_READ) begin
            rd = mem[loc(sh[8:0])];
            drv = 1'b1;
            obit = 1'b0;
        end else if (drv) begin
            obit = rd[7];
            rd = {rd[6:0], 1'b0};
        end
    end
    always @(negedge cs) begin
        off = (cnt >= 20) ? 8 : 0;
        if (sh[off+9 +: 3] == OP_EWEN && sh[off+7 +: 2] == 2'h3) ewen = 1'b1;
        if (ewen && cnt >= 20 && sh[17 +: 3] == OP_WRITE) begin
            mem[loc(sh[8 +: 9])] = sh[7:0];
            busy_cnt = prog_cyc;
            stat = 1'b1;
        end
        if (ewen && sh[off+9 +: 3] == OP_ERASE) begin
            mem[loc(sh[off +: 9])] = 8'hFF;
            busy_cnt = prog_cyc;
            stat = 1'b1;
        end
        cnt = 0;
        drv = 1'b0;
        // forget the frame so a bare deselect acts on nothing
        sh = 20'h0;
    end
    always @(posedge clk) begin
        junk = ~junk;
        if (busy_cnt != 0) busy_cnt--;
    end
    // released pin toggles so no stale level can pass for data
    assign dout = !cs ? junk : drv ? obit : stat ? (busy_cnt == 0) : junk;
endmodule

/* tb/tb_eeprom_config_loader.sv */
// testbench for the serial eeprom configuration loader
`timescale 1ns/1ps
module tb_eeprom_config_loader;
    import eeprom_loader_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, large_part = 1'b1, host_req = 1'b0;
    logic [1:0] host_cmd = 2'h0;
    logic [8:0] host_addr = 9'h0;
    logic [7:0] host_wdata = 8'h0, rdata, zbyte;
    logic sdo, busy, done, err, ldone, hold, valid, mload, we, cs, sck, sdi;
    logic [7:0] hrd, cdata;
    logic [8:0] caddr;
    logic [47:0] mac;
    logic [31:0] prog_cyc = 32'd20;
    logic got_err, mac_seen;
    int bad_count = 0, n_compared = 0, we_cnt = 0, cyc = 0;
    always #20 clk = ~clk;
    eeprom_config_loader #(.HALF_CYC(3), .TIMEOUT_CYC(50)) i_dut (
        .clk(clk), .resetn(resetn), .large_part(large_part),
        .host_req(host_req), .host_cmd(host_cmd), .host_addr(host_addr),
        .host_wdata(host_wdata), .eeprom_serial_out(sdo),
        .host_busy_ff(busy), .host_done_ff(done), .host_error_ff(err),
        .host_rdata_ff(hrd), .load_done_ff(ldone), .usb_hold_ff(hold),
        .cfg_valid_ff(valid), .mac_addr_ff(mac), .mac_load_ff(mload),
        .cfg_we_ff(we), .cfg_addr_ff(caddr), .cfg_data_ff(cdata),
        .eeprom_chip_select(cs), .eeprom_serial_clock(sck),
        .eeprom_serial_in(sdi));
    eeprom_model i_mem (.clk(clk), .large_part(large_part),
        .prog_cyc(prog_cyc), .cs(cs), .sclk(sck), .din(sdi), .dout(sdo));
    always @(negedge clk) begin
        if (we === 1'b1) we_cnt++;
        if (we === 1'b1 && caddr === 9'h00C) zbyte = cdata;
        if (mload === 1'b1) mac_seen = 1'b1;
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            summarize();
        end
    end
    // ========================================================
    // shared tasks
    task automatic summarize();
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(negedge clk) resetn = 1'b0;
        repeat (20) @(negedge clk);
        we_cnt = 0;
        mac_seen = 1'b0;
        zbyte = 8'hEE;
        resetn = 1'b1;
        for (int i = 0; i < 5000 && ldone !== 1'b1; i++) @(negedge clk);
        chk(hold, 1'b0);
    endtask
    task automatic host(input logic [1:0] c, input logic [8:0] a,
                        input logic [7:0] d);
        @(negedge clk);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        host_req = 1'b1;
        host_cmd = c;
        host_addr = a;
        host_wdata = d;
        @(negedge clk) host_req = 1'b0;
        got_err = 1'bx;
        for (int i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk);
        got_err = err;
        rdata = hrd;
        chk(done, 1'b1);
    endtask
    // ========================================================
    // scenarios
    task automatic t_blank();
        i_mem.mem[0] = 8'h5A;
        do_reset();
        chk(valid, 1'b0);
        chk(mac, MAC_RESET);
        chk(we_cnt, 0);
    endtask
    task automatic t_load();
        for (int i = 1; i < 34; i++) i_mem.mem[i] = 8'(i * 7 + 3);
        i_mem.mem[0] = PROGRAMMED_MARK;
        i_mem.mem[12] = 8'h00;
        do_reset();
        chk(valid, 1'b1);
        chk(mac, 48'h2D261F18110A);
        chk(mac_seen, 1'b1);
        chk(we_cnt, 33);
        chk(zbyte, 8'h00);
    endtask
    task automatic t_range();
        i_mem.mem[9'h0FF] = 8'h3C;
        i_mem.mem[9'h1FF] = 8'hC3;
        large_part = 1'b0;
        host(CMD_READ, 9'h1FF, 8'h00);
        chk(got_err, 1'b1);
        host(CMD_READ, 9'h0FF, 8'h00);
        chk({got_err, rdata}, 9'h03C);
        large_part = 1'b1;
        host(CMD_READ, 9'h1FF, 8'h00);
        chk({got_err, rdata}, 9'h0C3);
    endtask
    task automatic t_write();
        host(CMD_ENABLE, EWEN_ADDR, 8'h00);
        host(CMD_WRITE, 9'h155, 8'h96);
        chk({got_err, i_mem.mem[9'h155]}, 9'h096);
        host(CMD_READ, 9'h155, 8'h00);
        chk(rdata, 8'h96);
        host(CMD_ERASE, 9'h155, 8'h00);
        host(CMD_READ, 9'h155, 8'h00);
        chk(rdata, 8'hFF);
    endtask
    task automatic t_timeout();
        prog_cyc = 32'd1000;
        host(CMD_WRITE, 9'h0AA, 8'h5A);
        chk(got_err, 1'b1);
        repeat (1100) @(negedge clk);
        prog_cyc = 32'd20;
    endtask
    initial begin
        t_blank();
        t_load();
        t_range();
        t_write();
        t_timeout();
        summarize();
    end
endmodule

/* verilog/eeprom_config_loader.sv */
// serial eeprom configuration loader with host access path
`timescale 1ns/1ps
// Behaviour
// (RULE1) works with 256 or 512 byte parts
// (RULE2) always drives nine address bits
// (RULE3) eeprom is three-wire, byte organised
// (RULE4) loaded address goes to mac registers
// (RULE5) unprogrammed eeprom: skip load, host sets address
// (RULE6) load starts automatically after every reset
// (RULE7) usb transactions held until load finishes
// (RULE8) host may read, write and erase
// (RULE9) programmed only when location zero holds A5h
// (RULE10) zero length field means use default
// (RULE11) customary three-wire command sequence per access
module eeprom_config_loader
    import eeprom_loader_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int TIMEOUT_CYC = BUSY_TIMEOUT_CYC
) (
    input wire logic clk, // 25 MHz core clock
    input wire logic resetn, // async system reset, low
    input wire logic large_part, // high for 512-byte part
    input wire logic host_req, // one-cycle host command
    input wire logic [1:0] host_cmd, // read, write, erase, enable
    input wire logic [8:0] host_addr, // host location
    input wire logic [7:0] host_wdata, // host write byte
    input wire logic eeprom_serial_out, // data from eeprom pin
    output logic host_busy_ff, // host command not accepted
    output logic host_done_ff, // host command completed pulse
    output logic host_error_ff, // command refused or timed out
    output logic [7:0] host_rdata_ff, // byte read for host
    output logic load_done_ff, // load finished, usb may run
    output logic usb_hold_ff, // hold off usb transactions
    output logic cfg_valid_ff, // eeprom seen as programmed
    output logic [47:0] mac_addr_ff, // station address
    output logic mac_load_ff, // pulse: write mac registers
    output logic cfg_we_ff, // pulse: config byte write
    output logic [8:0] cfg_addr_ff, // config byte location
    output logic [7:0] cfg_data_ff, // config byte value
    output logic eeprom_chip_select, // chip select pin
    output logic eeprom_serial_clock, // serial clock pin
    output logic eeprom_serial_in // data toward eeprom pin
);
    initial begin
        if (HALF_CYC < 3 || TIMEOUT_CYC < 5)
            $error("eeprom_config_loader: bad timing parameters");
    end

    typedef enum logic [2:0] {
        RST_WAIT = 3'b000,
        RD_MARK = 3'b001,
        RD_CFG = 3'b010,
        FINISH = 3'b011,
        READY = 3'b100,
        HOST_RUN = 3'b101
    } ldr_state_type;

    ldr_state_type state_ff;
    logic sdo_meta_ff;
    logic sdo_sync_ff;
    logic [8:0] addr_ff;
    logic eng_start_ff;
    logic [2:0] eng_op_ff;
    logic [8:0] eng_addr_ff;
    logic [7:0] eng_wdata_ff;
    logic eng_busy;
    logic eng_done;
    logic eng_tmo;
    logic [7:0] eng_rdata;
    logic [8:0] last_addr;
    logic cs_q;
    logic sclk_q;
    logic sdi_q;

    // both part sizes share nine address bits; size only limits range [RULE1]
    assign last_addr = large_part ? LAST_ADDR_LARGE : LAST_ADDR_SMALL;
    assign eeprom_chip_select = cs_q;
    assign eeprom_serial_clock = sclk_q;
    assign eeprom_serial_in = sdi_q;

    // ========================================================
    // pin synchroniser
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdo_meta_ff <= 1'b0;
            sdo_sync_ff <= 1'b0;
        end else begin
            sdo_meta_ff <= eeprom_serial_out;
            sdo_sync_ff <= sdo_meta_ff;
        end
    end

    eeprom_serial_engine #(
        .HALF_CYC(HALF_CYC),
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) engine (
        .clk(clk),
        .resetn(resetn),
        .start(eng_start_ff),
        .opcode(eng_op_ff),
        .addr(eng_addr_ff),
        .wdata(eng_wdata_ff),
        .sdo_sync(sdo_sync_ff),
        .busy(eng_busy),
        .done(eng_done),
        .timed_out(eng_tmo),
        .rdata(eng_rdata),
        .cs_ff(cs_q),
        .sclk_ff(sclk_q),
        .sdi_ff(sdi_q)
    );

    // ========================================================
    // sequencer: load after reset, then serve host
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= RST_WAIT;
            addr_ff <= 9'h000;
            eng_start_ff <= 1'b0;
            eng_op_ff <= OP_READ;
            eng_addr_ff <= 9'h000;
            eng_wdata_ff <= 8'h00;
        end else begin
            eng_start_ff <= 1'b0;
            unique case (state_ff)
                RST_WAIT: begin
                    // every reset restarts the load [RULE6]
                    eng_op_ff <= OP_READ;
                    eng_addr_ff <= ADDR_MARK;
                    eng_start_ff <= 1'b1;
                    state_ff <= RD_MARK;
                end
                RD_MARK: begin
                    if (eng_done) begin
                        if (eng_rdata == PROGRAMMED_MARK) begin // [RULE9]
                            addr_ff <= ADDR_MAC_FIRST;
                            eng_addr_ff <= ADDR_MAC_FIRST;
                            eng_start_ff <= 1'b1;
                            state_ff <= RD_CFG;
                        end else begin
                            state_ff <= FINISH; // [RULE5]
                        end
                    end
                end
                RD_CFG: begin
                    if (eng_done) begin
                        if (addr_ff == ADDR_CFG_LAST) begin
                            state_ff <= FINISH;
                        end else begin
                            addr_ff <= addr_ff + 9'h001;
                            eng_addr_ff <= addr_ff + 9'h001;
                            eng_start_ff <= 1'b1;
                        end
                    end
                end
                FINISH: begin
                    state_ff <= READY;
                end
                READY: begin
                    // host access to eeprom contents [RULE8]
                    if (host_req && host_addr <= last_addr) begin
                        unique case (host_cmd)
                            CMD_READ: eng_op_ff <= OP_READ;
                            CMD_WRITE: eng_op_ff <= OP_WRITE;
                            CMD_ERASE: eng_op_ff <= OP_ERASE;
                            CMD_ENABLE: eng_op_ff <= OP_EWEN;
                        endcase
                        eng_addr_ff <= (host_cmd == CMD_ENABLE) ?
                            EWEN_ADDR : host_addr;
                        eng_wdata_ff <= host_wdata;
                        eng_start_ff <= 1'b1;
                        state_ff <= HOST_RUN;
                    end
                end
                HOST_RUN: begin
                    if (eng_done) begin
                        state_ff <= READY;
                    end
                end
                default: begin
                    state_ff <= RST_WAIT;
                end
            endcase
        end
    end

    // ========================================================
    // configuration outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_valid_ff <= 1'b0;
            mac_addr_ff <= MAC_RESET;
            mac_load_ff <= 1'b0;
            cfg_we_ff <= 1'b0;
            cfg_addr_ff <= 9'h000;
            cfg_data_ff <= 8'h00;
        end else begin
            mac_load_ff <= 1'b0;
            cfg_we_ff <= 1'b0;
            if (state_ff == RD_MARK && eng_done) begin
                cfg_valid_ff <= (eng_rdata == PROGRAMMED_MARK); // [RULE9]
            end
            if (state_ff == RD_CFG && eng_done) begin
                // zero lengths pass through; consumer keeps defaults
                cfg_we_ff <= 1'b1; // [RULE10]
                cfg_addr_ff <= addr_ff;
                cfg_data_ff <= eng_rdata;
                if (addr_ff <= ADDR_MAC_LAST) begin
                    // byte n lands in bits 8n-1..8n-8 [RULE4]
                    mac_addr_ff[(addr_ff[2:0] - 3'h1) * 8 +: 8] <= eng_rdata;
                end
                if (addr_ff == ADDR_MAC_LAST) begin
                    mac_load_ff <= 1'b1; // [RULE4]
                end
            end
        end
    end

    // ========================================================
    // usb hold-off and host status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            load_done_ff <= 1'b0;
            usb_hold_ff <= 1'b1;
            host_busy_ff <= 1'b1;
            host_done_ff <= 1'b0;
            host_error_ff <= 1'b0;
            host_rdata_ff <= 8'h00;
        end else begin
            host_done_ff <= 1'b0;
            if (state_ff == FINISH) begin
                load_done_ff <= 1'b1;
                usb_hold_ff <= 1'b0; // [RULE7]
            end
            host_busy_ff <= (state_ff != READY) || eng_busy ||
                eng_start_ff || (host_req && host_addr <= last_addr);
            if (state_ff == READY && host_req) begin
                host_error_ff <= (host_addr > last_addr);
                host_done_ff <= (host_addr > last_addr);
            end
            if (state_ff == HOST_RUN && eng_done) begin
                host_done_ff <= 1'b1;
                host_error_ff <= eng_tmo;
                host_rdata_ff <= eng_rdata;
            end
        end
    end
endmodule

/* verilog/eeprom_serial_engine.sv */
// one three-wire serial eeprom access: shift out, read back, wait busy
`timescale 1ns/1ps
module eeprom_serial_engine
    import eeprom_loader_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int TIMEOUT_CYC = BUSY_TIMEOUT_CYC
) (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, low
    input wire logic start, // one-cycle request
    input wire logic [2:0] opcode, // start bit and opcode
    input wire logic [8:0] addr, // nine-bit location
    input wire logic [7:0] wdata, // byte to write
    input wire logic sdo_sync, // synchronised eeprom data out
    output logic busy, // access running
    output logic done, // one-cycle completion pulse
    output logic timed_out, // write or erase never finished, with done
    output logic [7:0] rdata, // byte read
    output logic cs_ff, // chip select
    output logic sclk_ff, // serial clock
    output logic sdi_ff // data toward eeprom
);
    initial begin
        // read bits need three clocks to cross the synchroniser
        if (HALF_CYC < 3 || TIMEOUT_CYC < 5)
            $error("eeprom_serial_engine: bad timing parameters");
    end

    typedef enum logic [1:0] {
        IDLE = 2'b00,
        SHIFT = 2'b01,
        GAP = 2'b10,
        WAIT = 2'b11
    } eng_state_type;

    eng_state_type state_ff;
    logic [19:0] sreg_ff;
    logic [4:0] nbits_ff;
    logic [15:0] half_ff;
    logic [31:0] tmo_ff;
    logic is_read_ff;
    logic needs_wait_ff;
    logic done_ff;
    logic tmo_flag_ff;
    logic [7:0] rdata_ff;
    logic tick;

    assign tick = (half_ff == 16'(HALF_CYC - 1));
    assign busy = (state_ff != IDLE);
    assign done = done_ff;
    assign timed_out = tmo_flag_ff;
    assign rdata = rdata_ff;

    // ========================================================
    // half-period timer for the serial clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            half_ff <= 16'h0000;
        end else if (state_ff == IDLE || tick) begin
            half_ff <= 16'h0000;
        end else begin
            half_ff <= half_ff + 16'h0001;
        end
    end

    // ========================================================
    // command sequence: 3 op bits, 9 address bits, then 8 data bits on write or read only [RULE11]
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= IDLE;
            sreg_ff <= 20'h00000;
            nbits_ff <= 5'h00;
            tmo_ff <= 32'h0;
            is_read_ff <= 1'b0;
            needs_wait_ff <= 1'b0;
            done_ff <= 1'b0;
            tmo_flag_ff <= 1'b0;
            rdata_ff <= 8'h00;
            cs_ff <= 1'b0;
            sclk_ff <= 1'b0;
            sdi_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                IDLE: begin
                    if (start) begin
                        // nine address bits always driven [RULE2]
                        sreg_ff <= {opcode, addr, wdata};
                        is_read_ff <= (opcode == OP_READ);
                        needs_wait_ff <= (opcode == OP_WRITE) ||
                            (opcode == OP_ERASE);
                        nbits_ff <= (opcode == OP_WRITE) ? 5'h14 : 5'h0C;
                        tmo_flag_ff <= 1'b0;
                        cs_ff <= 1'b1;
                        sdi_ff <= opcode[2];
                        state_ff <= SHIFT;
                    end
                end
                SHIFT: begin
                    if (tick) begin
                        sclk_ff <= ~sclk_ff;
                        if (sclk_ff) begin
                            // falling edge: present next bit
                            // data out moves on the rise; take it half a
                            // period later, once through the synchroniser
                            if (nbits_ff <= 5'h08 && !is_read_ff &&
                                !needs_wait_ff) begin
                                rdata_ff <= {rdata_ff[6:0], sdo_sync};
                            end
                            nbits_ff <= nbits_ff - 5'h01;
                            sreg_ff <= {sreg_ff[18:0], 1'b0};
                            sdi_ff <= sreg_ff[18];
                            if (nbits_ff == 5'h01) begin
                                sdi_ff <= 1'b0;
                                if (is_read_ff) begin
                                    nbits_ff <= 5'h08;
                                    is_read_ff <= 1'b0;
                                end else begin
                                    state_ff <= GAP;
                                end
                            end
                        end
                    end
                end
                GAP: begin
                    if (tick) begin
                        // deselect: the part starts programming on it
                        cs_ff <= 1'b0;
                        tmo_ff <= 32'h0;
                        if (needs_wait_ff) begin
                            state_ff <= WAIT;
                        end else begin
                            done_ff <= 1'b1;
                            state_ff <= IDLE;
                        end
                    end
                end
                WAIT: begin
                    // ready shows as data out high while selected; the
                    // first cycles still carry the deselected level
                    cs_ff <= 1'b1;
                    tmo_ff <= tmo_ff + 32'h1;
                    if ((sdo_sync && tmo_ff >= READY_SETTLE_CYC) ||
                        tmo_ff == 32'(TIMEOUT_CYC - 1)) begin
                        tmo_flag_ff <= !(sdo_sync &&
                            tmo_ff >= READY_SETTLE_CYC);
                        cs_ff <= 1'b0;
                        done_ff <= 1'b1;
                        state_ff <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule
